//--- src/mba_arbiter.sv
// Multi-master bus arbiter: one processor onto a shared bus.
// Assumes the bus clock and all bus pins are asynchronous to CLK_SYS_I;
// open-drain lines are resolved outside from the output enables.
`timescale 1ns/10ps
module mba_arbiter
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic BCLK_I,
    input wire logic INIT_N_I,
    input wire logic PRIORITY_IN_N_I,
    input wire logic BUSY_N_I,
    input wire logic COMMON_REQUEST_N_I,
    input wire logic ANY_REQUEST_STRAP_I,
    input wire logic [2:0] STATUS_N_I,
    output logic BUSY_N_O,
    output logic BUSY_N_OE_O,
    output logic COMMON_REQUEST_N_O,
    output logic COMMON_REQUEST_N_OE_O,
    output logic BUS_REQUEST_N_O,
    output logic PRIORITY_OUT_N_O,
    output logic ADDRESS_ENABLE_N_O
);
    import mba_pkg::*;

    // ========================================================================
    // Input synchronisation.
    // ========================================================================
    logic [SYNC_W-1:0] pins_raw; // Raw pins gathered for the synchroniser.
    logic [SYNC_W-1:0] pins_s; // Synchronised copy of the pins.

    assign pins_raw = {STATUS_N_I, ANY_REQUEST_STRAP_I, INIT_N_I,
                       COMMON_REQUEST_N_I, BUSY_N_I, PRIORITY_IN_N_I, BCLK_I};

    mba_sync #(
        .W(SYNC_W),
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .CLK_SYS_I(CLK_SYS_I),
        .RST_I(RST_I),
        .d_i(pins_raw),
        .q_o(pins_s)
    );

    // Named views of the synchronised pins.
    logic bclk_s;
    logic prio_n_s;
    logic busy_n_s;
    logic creq_n_s;
    logic init_n_s;
    logic strap_s;
    logic [2:0] stat_s;

    assign bclk_s = pins_s[SI_BCLK];
    assign prio_n_s = pins_s[SI_PRIO_N];
    assign busy_n_s = pins_s[SI_BUSY_N];
    assign creq_n_s = pins_s[SI_CREQ_N];
    assign init_n_s = pins_s[SI_INIT_N];
    assign strap_s = pins_s[SI_STRAP];
    assign stat_s = pins_s[SI_STAT +: 3];

    // ========================================================================
    // Bus clock edge detection.
    // ========================================================================
    logic bclk_prev_r; // Previous synchronised bus clock level.
    logic bclk_fall; // One-cycle enable on each falling bus clock edge.

    // Track the bus clock so its falling edges become enables.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I)
            bclk_prev_r <= 1'b0;
        else
            bclk_prev_r <= bclk_s;
    end

    assign bclk_fall = bclk_prev_r & ~bclk_s;

    // ========================================================================
    // Processor status decode.
    // ========================================================================
    logic stat_halt; // Halt status seen on the status lines.
    logic stat_idle; // Idle status: the running transfer cycle has completed.
    logic proc_req; // Processor wants the shared bus: any active, non-halt status.
    logic kill; // Initialize held low on the shared bus.

    assign stat_halt = (stat_s == STAT_HALT);
    assign stat_idle = (stat_s == STAT_IDLE);
    assign proc_req = ~stat_halt & ~stat_idle;
    assign kill = ~init_n_s;

    // ========================================================================
    // Arbitration state machine.
    // ========================================================================
    mba_state_t state_r; // Current arbitration state.
    mba_state_t state_nxt; // Next state, settled before each clock edge.
    logic must_yield; // Surrender condition while holding the bus.

    // Yield at transfer end when a higher arbiter has priority, or when the
    // strap lets any requester on the common line force us off. Halt always
    // yields. An idle processor alone on the bus keeps it, which saves a
    // full re-arbitration for its next cycle.
    // Lost priority yields only once the transfer has ended.
    assign must_yield = stat_halt
                      | (stat_idle & (prio_n_s | (strap_s & ~creq_n_s)));

    // Next state; moves are taken only on falling bus clock edges.
    always_comb
    begin
        state_nxt = state_r;
        if (bclk_fall)
        begin
            unique case (state_r)
                // Waiting for the processor to start a bus cycle.
                ST_IDLE:
                begin
                    if (proc_req)
                        state_nxt = ST_WAIT;
                end
                // Requesting: need priority and a free busy line.
                ST_WAIT:
                begin
                    if (!prio_n_s && busy_n_s)
                    begin
                        state_nxt = ST_OWN;
                    end
                    else if (!proc_req)
                    begin
                        state_nxt = ST_IDLE;
                    end
                end
                // Holding the bus until forced off or halted.
                ST_OWN:
                begin
                    if (must_yield)
                        state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // State register; initialize drops ownership immediately.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || kill)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ========================================================================
    // Bus side outputs.
    // ========================================================================
    logic busy_out_r; // Busy line data; open-drain so only ever low when enabled.
    logic busy_oe_r; // Busy line pull-down enable.
    logic creq_out_r; // Common request data, constant low.
    logic creq_oe_r; // Common request pull-down enable.
    logic bus_request_n_n_r; // Bus request, active low.
    logic prio_out_n_r; // Priority passed down the chain, active low.
    logic aen_n_r; // Address enable to latches and bus controller, active low.

    // Busy drive follows ownership, so it changes only on falls or initialize.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || kill)
        begin
            busy_out_r <= 1'b0;
            busy_oe_r <= 1'b0;
        end
        else
        begin
            busy_out_r <= 1'b0;
            busy_oe_r <= (state_nxt == ST_OWN);
        end
    end

    // Common request is pulled only while we wait on an occupied bus.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || kill)
        begin
            creq_out_r <= 1'b0;
            creq_oe_r <= 1'b0;
        end
        else
        begin
            creq_out_r <= 1'b0;
            creq_oe_r <= (state_nxt == ST_WAIT) && !busy_n_s;
        end
    end

    // Request and priority-out; priority passes on only when idle.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || kill)
        begin
            bus_request_n_n_r <= 1'b1;
            prio_out_n_r <= 1'b1;
        end
        else
        begin
            bus_request_n_n_r <= (state_nxt == ST_IDLE);
            prio_out_n_r <= !((state_nxt == ST_IDLE) && !prio_n_s);
        end
    end

    // Address enable: drivers float unless we own the shared bus, which
    // stalls the processor in wait states until the bus is ours.
    always_ff @(posedge CLK_SYS_I)
    begin
        if (RST_I || kill)
            aen_n_r <= 1'b1;
        else
        begin
            aen_n_r <= (state_nxt != ST_OWN);
        end
    end

    assign BUSY_N_O = busy_out_r;
    assign BUSY_N_OE_O = busy_oe_r;
    assign COMMON_REQUEST_N_O = creq_out_r;
    assign COMMON_REQUEST_N_OE_O = creq_oe_r;
    assign BUS_REQUEST_N_O = bus_request_n_n_r;
    assign PRIORITY_OUT_N_O = prio_out_n_r;
    assign ADDRESS_ENABLE_N_O = aen_n_r;

    // ========================================================================
    // Assertions.
    // ========================================================================
    property p_busy_on_fall;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        $changed(busy_oe_r) |-> $past(bclk_fall) || $past(kill);
    endproperty
    a_busy_on_fall: assert property (p_busy_on_fall)
        else $error("Busy drive changed off a bus clock fall.");
    property p_take_rules;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        $rose(busy_oe_r) |-> $past(!prio_n_s && busy_n_s && bclk_fall);
    endproperty
    a_take_rules: assert property (p_take_rules)
        else $error("Bus taken without priority or while busy.");
    property p_aen_owner;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        busy_oe_r |-> !aen_n_r ##1 (aen_n_r == !busy_oe_r);
    endproperty
    a_aen_owner: assert property (p_aen_owner)
        else $error("Address enable does not follow ownership.");
    property p_float_not_owner;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        !busy_oe_r |-> aen_n_r;
    endproperty
    a_float_not_owner: assert property (p_float_not_owner)
        else $error("Drivers enabled without owning the bus.");
    property p_creq_not_owner;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        creq_oe_r |-> !busy_oe_r && !bus_request_n_n_r;
    endproperty
    a_creq_not_owner: assert property (p_creq_not_owner)
        else $error("Owner or idle arbiter pulls common request.");
    property p_prio_pass;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        !prio_out_n_r |-> $past(!prio_n_s) && bus_request_n_n_r && !busy_oe_r;
    endproperty
    a_prio_pass: assert property (p_prio_pass)
        else $error("Priority passed while requesting or owning.");
    property p_release_cause;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        $fell(busy_oe_r) && !$past(kill) |-> $past(stat_halt || stat_idle);
    endproperty
    a_release_cause: assert property (p_release_cause)
        else $error("Bus released mid transfer without halt.");
    property p_init_clears;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        kill |=> !busy_oe_r && bus_request_n_n_r && aen_n_r;
    endproperty
    a_init_clears: assert property (p_init_clears)
        else $error("Arbiter holds bus after initialize.");
    property p_keep_alone;
        @(posedge CLK_SYS_I) disable iff (RST_I)
        busy_oe_r && bclk_fall && !kill && !stat_halt && !prio_n_s && creq_n_s
            |=> busy_oe_r;
    endproperty
    a_keep_alone: assert property (p_keep_alone)
        else $error("Bus given up with no other requester.");

endmodule : mba_arbiter

//--- include/mba_pkg.sv
// Shared constants and types for the multi-master bus arbiter.
// Assumes a single system clock; every pin is sampled through mba_sync.
package mba_pkg;

    // ========================================================================
    // Processor status codes (active-low status lines, S2 S1 S0).
    // ========================================================================
    // Halt status: the only voluntary reason to give up the shared bus.
    localparam logic [2:0] STAT_HALT = 3'h3;
    // Passive or idle status: a transfer cycle has ended.
    localparam logic [2:0] STAT_IDLE = 3'h7;

    // ========================================================================
    // Layout of the synchronised pin vector.
    // ========================================================================
    localparam int SYNC_W = 9;
    localparam int SI_BCLK = 0;
    localparam int SI_PRIO_N = 1;
    localparam int SI_BUSY_N = 2;
    localparam int SI_CREQ_N = 3;
    localparam int SI_INIT_N = 4;
    localparam int SI_STRAP = 5;
    localparam int SI_STAT = 6;
    // Pins rest at their inactive level while reset holds the stages.
    localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1DF;

    // ========================================================================
    // Arbitration state machine.
    // ========================================================================
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_WAIT,
        ST_OWN
    } mba_state_t;

endpackage : mba_pkg

//--- src/mba_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes each bit is an independent level; no bit relation is kept.
`timescale 1ns/10ps
module mba_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ========================================================================
    // Per-bit flip-flop pair.
    // ========================================================================
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++)
        begin : g_bit
            // First stage; read only by the second stage.
            logic meta_r;
            // Second stage; the only value logic may look at.
            logic safe_r;
            // Both stages take the rest value on reset.
            always_ff @(posedge CLK_SYS_I)
            begin
                if (RST_I)
                begin
                    meta_r <= RST_VAL[gi];
                    safe_r <= RST_VAL[gi];
                end
                else
                begin
                    meta_r <= d_i[gi];
                    safe_r <= meta_r;
                end
            end
            assign q_o[gi] = safe_r;
        end
    endgenerate

endmodule : mba_sync

//--- bench/mba_peer_model.sv
// Peer arbiters and the priority resolver that face the arbiter under test.
// Assumes the bench sets the peer controls between system clock edges.
`timescale 1ns/10ps
module mba_peer_model
(
    input wire logic uut_busy_n_i,
    input wire logic uut_busy_oe_i,
    input wire logic uut_creq_n_i,
    input wire logic uut_creq_oe_i,
    input wire logic uut_bus_request_n_n_i,
    input wire logic hi_req_i,
    input wire logic lo_req_i,
    input wire logic top_grant_i,
    output logic bclk_o,
    output logic busy_n_o,
    output logic creq_n_o,
    output logic prio_n_o,
    output logic peer_own_o
);
    // ========================================================================
    // Bus clock and shared wires.
    // ========================================================================
    // Free-running bus clock
    // The phase offset keeps bus edges away from system clock edges.
    initial
    begin
        bclk_o = 1'b0;
        #1.3;
        forever #16 bclk_o = ~bclk_o;
    end

    // Pulled-up open-drain wires
    // A released wire floats high; any party driving low wins.
    assign busy_n_o = !((uut_busy_oe_i && !uut_busy_n_i) || peer_own_o);
    assign creq_n_o = !((uut_creq_oe_i && !uut_creq_n_i) || lo_req_i);

    // ========================================================================
    // Peers and priority.
    // ========================================================================
    initial peer_own_o = 1'b0;
    initial prio_n_o = 1'b1;

    // Higher peer seizes only a free bus
    // It takes the bus at a fall while busy is high and quits when done.
    always @(negedge bclk_o)
    begin
        if (!hi_req_i)
            peer_own_o <= 1'b0;
        else if (busy_n_o)
            peer_own_o <= 1'b1;
    end

    // Bench rotates priority via top_grant
    // Resolved at the rise, so it has settled by the next fall.
    always @(posedge bclk_o)
    begin
        prio_n_o <= !(!hi_req_i && (!uut_bus_request_n_n_i || top_grant_i));
    end
endmodule : mba_peer_model

//--- bench/mba_tb.sv
// Self-checking bench for the bus arbiter, one task per scenario.
// Assumes mba_peer_model stands for the peers and the priority resolver.
`timescale 1ns/10ps
module tb;
    import mba_pkg::*;
    // Memory command status: any code but idle or halt asks for the bus.
    localparam logic [2:0] ST_ACT = 3'h4;
    logic clk, rst, init_n, strap, hi_req, lo_req, top_grant;
    logic [2:0] status_n;
    logic bclk, busy_n, creq_n, prio_n, peer_own;
    logic busy_o, busy_oe, creq_o, creq_oe, bus_request_n_n, prio_out_n, aen_n;
    int num_errors = 0;
    int n_compared = 0;

    // ========================================================================
    // Design, partner and clock.
    // ========================================================================
    mba_arbiter uut
    (
        .CLK_SYS_I(clk),
        .RST_I(rst),
        .BCLK_I(bclk),
        .INIT_N_I(init_n),
        .PRIORITY_IN_N_I(prio_n),
        .BUSY_N_I(busy_n),
        .COMMON_REQUEST_N_I(creq_n),
        .ANY_REQUEST_STRAP_I(strap),
        .STATUS_N_I(status_n),
        .BUSY_N_O(busy_o),
        .BUSY_N_OE_O(busy_oe),
        .COMMON_REQUEST_N_O(creq_o),
        .COMMON_REQUEST_N_OE_O(creq_oe),
        .BUS_REQUEST_N_O(bus_request_n_n),
        .PRIORITY_OUT_N_O(prio_out_n),
        .ADDRESS_ENABLE_N_O(aen_n)
    );
    mba_peer_model peer
    (
        .uut_busy_n_i(busy_o),
        .uut_busy_oe_i(busy_oe),
        .uut_creq_n_i(creq_o),
        .uut_creq_oe_i(creq_oe),
        .uut_bus_request_n_n_i(bus_request_n_n),
        .hi_req_i(hi_req),
        .lo_req_i(lo_req),
        .top_grant_i(top_grant),
        .bclk_o(bclk),
        .busy_n_o(busy_n),
        .creq_n_o(creq_n),
        .prio_n_o(prio_n),
        .peer_own_o(peer_own)
    );
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ========================================================================
    // Helpers. All waits end on a falling system edge, where inputs change.
    // ========================================================================
    task automatic chk(input logic got, input logic exp, input string what);
        begin
            n_compared++;
            if (got !== exp)
            begin
                num_errors++;
                $display("unexpected at %0t: %s got %b", $time, what, got);
            end
        end
    endtask : chk

    // Synchroniser plus registered output take up to three system clocks.
    task automatic wait_bclk(input int n);
        begin
            repeat (n) @(negedge bclk);
            repeat (6) @(negedge clk);
        end
    endtask : wait_bclk

    // Bounded wait for the ownership flag, then judged.
    task automatic await_owner(input logic exp, input int bclks);
        int n;
        begin
            n = 0;
            while (busy_oe !== exp && n < bclks * 8 + 8)
            begin
                @(negedge clk);
                n++;
            end
            chk(busy_oe, exp, "ownership");
        end
    endtask : await_owner

    task automatic report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask : report_and_stop

    // ========================================================================
    // Scenarios.
    // ========================================================================
    task automatic t_reset;
        begin
            @(negedge clk);
            chk(busy_oe, 1'b0, "busy drive after reset");
            chk(bus_request_n_n, 1'b1, "request after reset");
            chk(aen_n, 1'b1, "address enable after reset");
            chk(prio_out_n, 1'b1, "priority out after reset");
            $display("test reset done");
        end
    endtask : t_reset

    task automatic t_acquire;
        begin
            status_n = ST_ACT;
            wait_bclk(2);
            chk(bus_request_n_n, 1'b0, "request raised");
            await_owner(1'b1, 4);
            chk(aen_n, 1'b0, "drivers enabled");
            chk(busy_n, 1'b0, "busy wire held low");
            chk(creq_oe, 1'b0, "owner quiet on common request");
            status_n = STAT_IDLE;
            wait_bclk(4);
            chk(busy_oe, 1'b1, "bus kept while alone");
            $display("test acquire done");
        end
    endtask : t_acquire

    // A higher peer asks in mid-transfer; the owner yields only at its end.
    task automatic t_preempt;
        begin
            status_n = ST_ACT;
            hi_req = 1'b1;
            wait_bclk(3);
            chk(busy_oe, 1'b1, "kept until transfer ends");
            status_n = STAT_IDLE;
            await_owner(1'b0, 3);
            chk(aen_n, 1'b1, "drivers off after yield");
            status_n = ST_ACT;
            wait_bclk(3);
            chk(peer_own, 1'b1, "peer holds the bus");
            chk(busy_oe, 1'b0, "no take while busy low");
            chk(aen_n, 1'b1, "drivers off while waiting");
            chk(creq_n, 1'b0, "waiter pulls common request");
            hi_req = 1'b0;
            await_owner(1'b1, 4);
            $display("test preempt done");
        end
    endtask : t_preempt

    task automatic t_halt;
        begin
            status_n = STAT_HALT;
            await_owner(1'b0, 3);
            chk(bus_request_n_n, 1'b1, "request dropped on halt");
            status_n = STAT_IDLE;
            $display("test halt done");
        end
    endtask : t_halt

    // Lower requester: only the strap lets it force the owner off.
    task automatic t_strap;
        begin
            for (int s = 0; s < 2; s++)
            begin
                status_n = ST_ACT;
                await_owner(1'b1, 4);
                strap = s[0];
                lo_req = 1'b1;
                status_n = STAT_IDLE;
                wait_bclk(4);
                chk(busy_oe, ~s[0], "lower requester versus strap");
                lo_req = 1'b0;
            end
            strap = 1'b0;
            $display("test strap done");
        end
    endtask : t_strap

    task automatic t_prio_out;
        begin
            top_grant = 1'b1;
            wait_bclk(2);
            chk(prio_out_n, 1'b0, "priority passed when idle");
            status_n = ST_ACT;
            wait_bclk(2);
            chk(prio_out_n, 1'b1, "priority kept while busy");
            top_grant = 1'b0;
            $display("test priority out done");
        end
    endtask : t_prio_out

    task automatic t_init;
        begin
            await_owner(1'b1, 4);
            init_n = 1'b0;
            repeat (8) @(negedge clk);
            chk(busy_oe, 1'b0, "initialize frees the bus");
            chk(bus_request_n_n, 1'b1, "initialize clears request");
            chk(aen_n, 1'b1, "initialize disables drivers");
            status_n = STAT_IDLE;
            init_n = 1'b1;
            $display("test initialize done");
        end
    endtask : t_init

    // ========================================================================
    // Main sequence and watchdog.
    // ========================================================================
    initial
    begin
        rst = 1'b1;
        init_n = 1'b1;
        strap = 1'b0;
        status_n = STAT_IDLE;
        hi_req = 1'b0;
        lo_req = 1'b0;
        top_grant = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_acquire();
        t_preempt();
        t_halt();
        t_strap();
        t_prio_out();
        t_init();
        report_and_stop();
    end

    // The scenarios need a few hundred clocks; this leaves ample margin.
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : tb
